// ---- design/tevp_timer.sv ----
// 16-bit event / window / pulse-width / pulse-generator timer
// What the block, its software and its inputs must do
// [R01] event mode: count selected edge of pin
// [R02] event mode: match on opposite edge, clear
// [R03] source holds pin levels two cycles minimum
// [R04] auto-capture copies counter each source tick
// [R05] software waits a tick before capture read
// [R06] window mode: gated source ticks, match clears
// [R07] window pulses much slower than source clock
// [R08] width mode: start on trigger, count ticks
// [R09] single edge: capture, irq, clear, rearm
// [R10] double edge: capture twice, clear on trigger
// [R11] software reads capture before next trigger
// [R12] single edge counter rests at one
// [R13] software drops first capture after start
// [R14] pulse mode: command or edge start, oneshot
// [R15] continuous: duty toggles, period toggles clears
// [R16] stopping keeps current output level
// [R17] oneshot: period match stops and clears start
// [R18] output pin is inverse of flip-flop
// [R19] reinit flip-flop via timer mode first
// [R20] period must exceed duty in pulse mode
// [R21] write duty only after pulse mode set
// [R22] runtime compare updates exceed current count
// [R23] change settings only while stopped
// [R24] compare value commits after upper byte write
// [R25] interrupt is one-cycle pulse on event
`timescale 1ns/1ps
`default_nettype none
module tevp_timer
  import tevp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer pins
  input wire logic timer_input_pin,
  output logic pulse_output_n,
  output logic timer_irq
);
  // ------
  // registers and state
  // ------
  logic [TEVP_CTRL_W-1:0] timer_control_reg; // software settings
  logic [15:0] period_compare_reg; // active period value
  logic [15:0] duty_capture_reg; // duty value or captured count
  logic [15:0] period_stage_reg; // staged period bytes
  logic [15:0] duty_stage_reg; // staged duty bytes
  logic period_pend_reg; // upper byte seen, commit pending
  logic duty_pend_reg; // upper byte seen, commit pending
  logic [15:0] count_reg; // the up-counter
  logic out_ff_reg; // timer output flip-flop
  logic irq_reg; // registered interrupt pulse
  logic pnout_reg; // registered active-low pin
  logic pready_reg; // one wait state then ready
  logic pslverr_reg; // unmapped access flag
  logic [31:0] prdata_reg; // read data latch
  tevp_state_t state_reg; // sequencer state
  tevp_state_t state_next; // sequencer next state

  // ------
  // control field views
  // ------
  logic [2:0] operating_mode_select;
  logic [1:0] source_clock_select;
  logic [1:0] start_control;
  logic auto_capture_enable;
  logic capture_edge_mode;
  logic oneshot_select;
  logic output_initial_level;
  logic window_low_active;
  assign operating_mode_select = timer_control_reg[TEVP_MODE_LSB +: 3];
  assign source_clock_select = timer_control_reg[TEVP_CKSEL_LSB +: 2];
  assign start_control = timer_control_reg[TEVP_START_LSB +: 2];
  assign auto_capture_enable = timer_control_reg[TEVP_ACAP_BIT];
  assign capture_edge_mode = timer_control_reg[TEVP_MCAP_BIT];
  assign oneshot_select = timer_control_reg[TEVP_ONESHOT_BIT];
  assign output_initial_level = timer_control_reg[TEVP_TFF_BIT];
  assign window_low_active = timer_control_reg[TEVP_WINPOL_BIT];

  // ------
  // helpers: source tick and pin edges
  // ------
  logic src_tick; // one-cycle source clock enable
  logic pin_rise; // rising edge of the input pin
  logic pin_fall; // falling edge of the input pin

  tevp_prescaler u_presc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sel(source_clock_select),
    .tick(src_tick)
  );

  tevp_edge_det u_edge (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(timer_input_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ------
  // apb decode
  // ------
  logic running; // start control not stopped
  logic trig_edge; // selected trigger / count edge
  logic opp_edge; // edge opposite the trigger
  logic acc_done; // access completes this edge
  logic wr_en; // write takes effect
  logic mapped; // address hits a register
  logic wr_ctrl;
  logic wr_period;
  logic wr_duty;
  logic hw_stop; // oneshot auto-clear of start control
  logic evt; // any interrupt event this cycle

  assign running = (start_control != TEVP_START_STOP);
  // falling selection when code is 11, rising otherwise
  assign trig_edge = (start_control == TEVP_START_FALL) ? pin_fall : pin_rise;
  assign opp_edge = (start_control == TEVP_START_FALL) ? pin_rise : pin_fall;
  assign acc_done = psel & penable & pready_reg;
  assign wr_en = acc_done & pwrite;
  assign mapped = (paddr == TEVP_OFS_CTRL) | (paddr == TEVP_OFS_PERIOD) |
                  (paddr == TEVP_OFS_DUTY) | (paddr == TEVP_OFS_STATUS);
  assign wr_ctrl = wr_en & (paddr == TEVP_OFS_CTRL);
  assign wr_period = wr_en & (paddr == TEVP_OFS_PERIOD);
  assign wr_duty = wr_en & (paddr == TEVP_OFS_DUTY);

  // apb handshake: one wait state, registered answer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel & penable & ~pready_reg) begin
        pslverr_reg <= ~mapped;
        case (paddr)
          TEVP_OFS_CTRL: prdata_reg <= {20'h00000, timer_control_reg};
          TEVP_OFS_PERIOD: prdata_reg <= {16'h0000, period_compare_reg};
          TEVP_OFS_DUTY: prdata_reg <= {16'h0000, duty_capture_reg};
          TEVP_OFS_STATUS: prdata_reg <= {13'h0000, running, out_ff_reg,
                                          state_reg != TEVP_ST_IDLE,
                                          count_reg};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // software write wins over the oneshot clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timer_control_reg <= TEVP_CTRL_RST;
    end else if (wr_ctrl) begin
      if (pstrb[0]) begin
        timer_control_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        timer_control_reg[TEVP_CTRL_W-1:8] <= pwdata[TEVP_CTRL_W-1:8];
      end
    end else if (hw_stop) begin
      timer_control_reg[TEVP_START_LSB +: 2] <= TEVP_START_STOP; // R17
    end
  end

  // ------------------------------------------------------------
  // compare staging: upper byte arms, source tick commits
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      period_stage_reg <= TEVP_CMP_RST;
      period_pend_reg <= 1'b0;
      period_compare_reg <= TEVP_CMP_RST;
    end else begin
      if (wr_period & pstrb[0]) begin
        period_stage_reg[7:0] <= pwdata[7:0];
      end
      if (wr_period & pstrb[1]) begin
        period_stage_reg[15:8] <= pwdata[15:8];
        period_pend_reg <= 1'b1; // R24
      end else if (period_pend_reg & src_tick) begin
        period_compare_reg <= period_stage_reg; // R24
        period_pend_reg <= 1'b0;
      end
    end
  end

  // duty staging; the live register also takes captures
  logic cap_evt; // capture strobe
  logic [15:0] cap_val; // value to capture
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      duty_stage_reg <= TEVP_CMP_RST;
      duty_pend_reg <= 1'b0;
      duty_capture_reg <= TEVP_CMP_RST;
    end else begin
      if (wr_duty & pstrb[0]) begin
        duty_stage_reg[7:0] <= pwdata[7:0];
      end
      if (wr_duty & pstrb[1]) begin
        duty_stage_reg[15:8] <= pwdata[15:8];
        duty_pend_reg <= 1'b1; // R24
      end else if (duty_pend_reg & src_tick) begin
        duty_pend_reg <= 1'b0;
      end
      // hardware capture outranks a pending software value
      if (cap_evt) begin
        duty_capture_reg <= cap_val;
      end else if (duty_pend_reg & src_tick & ~(wr_duty & pstrb[1])) begin
        duty_capture_reg <= duty_stage_reg; // R24
      end
    end
  end

  // ------------------------------------------------------------
  // counting engine
  // ------------------------------------------------------------
  logic [15:0] count_next;
  logic ppg_toggle; // output flip-flop toggle request
  logic period_hit; // counter equals period
  logic duty_hit; // counter equals duty
  logic win_open; // window level is active
  logic acap_mode; // modes allowing auto-capture

  assign period_hit = (count_reg == period_compare_reg);
  assign duty_hit = (count_reg == duty_capture_reg);
  assign win_open = timer_input_pin ^ window_low_active;
  assign acap_mode = (operating_mode_select == TEVP_MODE_TIMER) |
                     (operating_mode_select == TEVP_MODE_EVENT) |
                     (operating_mode_select == TEVP_MODE_WINDOW);

  // next counter, state, events per mode
  always_comb begin
    count_next = count_reg;
    state_next = state_reg;
    evt = 1'b0;
    cap_evt = 1'b0;
    cap_val = count_reg;
    ppg_toggle = 1'b0;
    hw_stop = 1'b0;
    if (!running) begin
      // stopped: clear counter, output level is left alone
      count_next = 16'h0000;
      state_next = TEVP_ST_IDLE; // R16
    end else begin
      case (operating_mode_select)
        TEVP_MODE_EVENT: begin
          // pin edges rely on levels held two machine cycles
          if (trig_edge) begin
            count_next = count_reg + 16'h0001; // R01 R03
          end else if (opp_edge && period_hit) begin
            count_next = 16'h0000; // R02
            evt = 1'b1; // R02
          end
        end
        TEVP_MODE_WINDOW: begin
          // gate sampled per tick; window must be much slower
          if (src_tick && win_open) begin
            if (period_hit) begin
              count_next = 16'h0000; // R06
              evt = 1'b1; // R06
            end else begin
              count_next = count_reg + 16'h0001; // R06 R07
            end
          end
        end
        TEVP_MODE_PWM: begin
          case (state_reg)
            TEVP_ST_IDLE: begin
              state_next = TEVP_ST_WAIT;
            end
            TEVP_ST_WAIT: begin
              if (trig_edge) begin
                state_next = TEVP_ST_COUNT; // R08
              end
            end
            TEVP_ST_COUNT: begin
              if (opp_edge) begin
                cap_evt = 1'b1; // R09 R10
                evt = 1'b1;
                if (capture_edge_mode) begin
                  count_next = 16'h0001; // R09 R12
                  state_next = TEVP_ST_WAIT; // R09
                end else begin
                  state_next = TEVP_ST_SECOND; // R10
                  if (src_tick) begin
                    count_next = count_reg + 16'h0001;
                  end
                end
              end else if (src_tick) begin
                count_next = count_reg + 16'h0001; // R08
              end
            end
            TEVP_ST_SECOND: begin
              if (trig_edge) begin
                cap_evt = 1'b1; // R10
                evt = 1'b1; // R10
                count_next = 16'h0000; // R10
                state_next = TEVP_ST_COUNT; // R10
              end else if (src_tick) begin
                count_next = count_reg + 16'h0001;
              end
            end
            default: begin
              state_next = TEVP_ST_IDLE;
            end
          endcase
        end
        TEVP_MODE_PPG: begin
          case (state_reg)
            TEVP_ST_IDLE: begin
              // command start runs at once, edge start waits
              if (start_control == TEVP_START_CMD) begin
                state_next = TEVP_ST_COUNT; // R14
              end else begin
                state_next = TEVP_ST_WAIT; // R14
              end
            end
            TEVP_ST_WAIT: begin
              if (trig_edge) begin
                state_next = TEVP_ST_COUNT; // R14
              end
            end
            TEVP_ST_COUNT: begin
              if (src_tick) begin
                if (period_hit) begin
                  ppg_toggle = 1'b1; // R15 R17
                  evt = 1'b1; // R15 R17
                  count_next = 16'h0000; // R15
                  if (oneshot_select) begin
                    hw_stop = 1'b1; // R17
                    state_next = TEVP_ST_IDLE; // R17
                  end
                end else begin
                  if (duty_hit) begin
                    ppg_toggle = 1'b1; // R15
                    evt = 1'b1; // R15
                  end
                  count_next = count_reg + 16'h0001; // R14
                end
              end
            end
            default: begin
              state_next = TEVP_ST_IDLE;
            end
          endcase
        end
        default: begin
          // timer mode: counter idles here
          count_next = count_reg;
        end
      endcase
    end
    // auto-capture follows the live counter on every tick
    if (auto_capture_enable && running && acap_mode && src_tick) begin
      cap_evt = 1'b1; // R04
      cap_val = count_reg; // R04
    end
  end

  // counter and sequencer state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_reg <= 16'h0000;
      state_reg <= TEVP_ST_IDLE;
    end else begin
      count_reg <= count_next;
      state_reg <= state_next;
    end
  end

  // ------
  // output flip-flop and pins
  // ------
  // stopped-time control writes load it: non-pulse mode clears it,
  // entering pulse mode loads the initial level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_ff_reg <= 1'b0; // R18
    end else if (wr_ctrl && !running && pstrb[0] && pstrb[1]) begin
      if (pwdata[TEVP_MODE_LSB +: 3] != TEVP_MODE_PPG) begin
        out_ff_reg <= 1'b0;
      end else if (operating_mode_select != TEVP_MODE_PPG) begin
        out_ff_reg <= pwdata[TEVP_TFF_BIT];
      end
    end else if (ppg_toggle) begin
      out_ff_reg <= ~out_ff_reg; // R15 R17
    end
  end

  // registered pins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pnout_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      pnout_reg <= ~out_ff_reg; // R18
      irq_reg <= evt; // R25
    end
  end

  assign pulse_output_n = pnout_reg;
  assign timer_irq = irq_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // initial level is only meaningful to software in pulse mode
  logic unused_ok;
  assign unused_ok = output_initial_level | pstrb[2] | pstrb[3];
endmodule : tevp_timer
`default_nettype wire

// ---- design/tevp_pkg.sv ----
// shared constants for the event/window/pulse timer block
package tevp_pkg;
  // ------
  // register byte offsets
  // ------
  localparam logic [7:0] TEVP_OFS_CTRL = 8'h00;
  localparam logic [7:0] TEVP_OFS_PERIOD = 8'h04;
  localparam logic [7:0] TEVP_OFS_DUTY = 8'h08;
  localparam logic [7:0] TEVP_OFS_STATUS = 8'h0C;
  // ------
  // control field positions
  // ------
  localparam int TEVP_CTRL_W = 12;
  localparam int TEVP_MODE_LSB = 0;
  localparam int TEVP_CKSEL_LSB = 3;
  localparam int TEVP_START_LSB = 5;
  localparam int TEVP_ACAP_BIT = 7;
  localparam int TEVP_MCAP_BIT = 8;
  localparam int TEVP_ONESHOT_BIT = 9;
  localparam int TEVP_TFF_BIT = 10;
  localparam int TEVP_WINPOL_BIT = 11;
  localparam logic [TEVP_CTRL_W-1:0] TEVP_CTRL_RST = 12'h000;
  localparam logic [15:0] TEVP_CMP_RST = 16'hFFFF;
  // ------
  // operating modes and start control codes
  // ------
  localparam logic [2:0] TEVP_MODE_TIMER = 3'h0;
  localparam logic [2:0] TEVP_MODE_EVENT = 3'h2;
  localparam logic [2:0] TEVP_MODE_WINDOW = 3'h3;
  localparam logic [2:0] TEVP_MODE_PWM = 3'h4;
  localparam logic [2:0] TEVP_MODE_PPG = 3'h5;
  localparam logic [1:0] TEVP_START_STOP = 2'h0;
  localparam logic [1:0] TEVP_START_CMD = 2'h1;
  localparam logic [1:0] TEVP_START_RISE = 2'h2;
  localparam logic [1:0] TEVP_START_FALL = 2'h3;
  // ------
  // source clock dividers: log2 of clk_sys cycles per tick
  // ------
  localparam int TEVP_DIV_SH0 = 7;
  localparam int TEVP_DIV_SH1 = 4;
  localparam int TEVP_DIV_SH2 = 1;
  localparam int TEVP_DIV_W = 8;
  // ------
  // measurement / generation sequencer
  // ------
  typedef enum logic [1:0] {
    TEVP_ST_IDLE = 2'b00,
    TEVP_ST_WAIT = 2'b01,
    TEVP_ST_COUNT = 2'b11,
    TEVP_ST_SECOND = 2'b10
  } tevp_state_t;
endpackage : tevp_pkg

// ---- design/tevp_prescaler.sv ----
// source clock divider giving one-cycle tick enables
`timescale 1ns/1ps
`default_nettype none
module tevp_prescaler
  import tevp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // selection and tick
  input wire logic [1:0] sel,
  output logic tick
);
  // ------
  // free-running divider
  // ------
  localparam int SH [3] = '{TEVP_DIV_SH0, TEVP_DIV_SH1, TEVP_DIV_SH2};
  logic [TEVP_DIV_W-1:0] div_reg; // never stops, so ticks stay periodic
  logic [2:0] taps; // one carry per divider ratio

  // divider counter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // carry out of the low bits for each ratio
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tap
      assign taps[gi] = &div_reg[SH[gi]-1:0];
    end
  endgenerate

  // code 3 reuses the fastest ratio
  always_comb begin
    tick = (sel == 2'h3) ? taps[2] : taps[sel];
  end
endmodule : tevp_prescaler
`default_nettype wire

// ---- design/tevp_edge_det.sv ----
// edge detector for the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tevp_edge_det (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // pin and edges
  input wire logic pin,
  output logic rise,
  output logic fall
);
  // ------
  // previous sample
  // ------
  logic prev_reg; // pin is already synchronous to clk_sys

  // remember last level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin;
    end
  end

  // one-cycle edge pulses
  always_comb begin
    rise = pin & ~prev_reg;
    fall = ~pin & prev_reg;
  end
endmodule : tevp_edge_det
`default_nettype wire

// ---- verif/tevp_timer_monitor.sv ----
// assertion checker for the timer bus and pin behaviour
`timescale 1ns/1ps
`default_nettype none
module tevp_timer_monitor
  import tevp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic timer_input_pin,
  input wire logic pulse_output_n,
  input wire logic timer_irq
);
  // ------
  // shadow of control writes
  // ------
  logic [11:0] ctl_reg; // last full control write
  logic [2:0] quiet_reg; // cycles since last bus answer
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // oneshot self-clear is not mirrored, so stop checks never see it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl_reg <= 12'h000;
    end else if (psel && penable && pready && pwrite &&
        paddr == TEVP_OFS_CTRL && pstrb[1:0] == 2'h3) begin
      ctl_reg <= pwdata[11:0];
    end
  end
  // saturating count keeps checks clear of write side effects
  always_ff @(posedge clk_sys) begin
    if (sys_rst || pready) begin
      quiet_reg <= 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_reg <= quiet_reg + 3'h1;
    end
  end
  wire logic ev_rise = ctl_reg[2:0] == TEVP_MODE_EVENT &&
    ctl_reg[6:5] == TEVP_START_RISE;
  wire logic halted = ctl_reg[6:5] == TEVP_START_STOP && quiet_reg == 3'h7;
  // ------
  // properties
  // ------
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  property p_rdy_wait; s_setup |=> s_answer; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("bus answer late");
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("stray error");
  property p_hole; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole data");
  property p_irq_one; timer_irq |=> !timer_irq; endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq wide");
  property p_rst_out; $fell(sys_rst) |-> pulse_output_n && !timer_irq; endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset level");
  property p_out_cause; $changed(pulse_output_n) |-> timer_irq ||
    $past(timer_irq) || $past(pready) || $past(pready, 2); endproperty
  a_out_cause: assert property (p_out_cause) else $error("toggle alone");
  property p_ev_edge; ev_rise && timer_irq |->
    !$past(timer_input_pin) && $past(timer_input_pin, 4); endproperty
  a_ev_edge: assert property (p_ev_edge) else $error("event irq edge");
  property p_stop; halted |-> $stable(pulse_output_n) && !timer_irq; endproperty
  a_stop: assert property (p_stop) else $error("stopped moved");
endmodule : tevp_timer_monitor
bind tevp_timer tevp_timer_monitor mon_u (.clk_sys, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .timer_input_pin, .pulse_output_n, .timer_irq);
`default_nettype wire

// ---- verif/tevp_pin_src.sv ----
// behavioural pulse source on the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tevp_pin_src (
  // clock
  input wire logic clk_sys,
  // driven pin
  output var logic pin
);
  // ------
  // level and pulse tasks
  // ------
  initial pin = 1'b0; // idle low
  // level change made just after an edge
  task automatic level(input logic v);
    @(posedge clk_sys);
    pin <= v;
  endtask : level
  // the source must hold levels two cycles minimum (R03), so two is the floor
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      level(1'b1);
      repeat (hi < 2 ? 2 : hi) @(posedge clk_sys);
      level(1'b0);
      repeat (lo < 2 ? 2 : lo) @(posedge clk_sys);
    end
  endtask : pulses
endmodule : tevp_pin_src
`default_nettype wire

// ---- verif/test_timer_event_window_pulse_gen.sv ----
// self-checking bench for the event, window and pulse timer
`timescale 1ns/1ps
`default_nettype none
module test_timer_event_window_pulse_gen
  import tevp_pkg::*;
;
  // ------
  // signals and scoreboard
  // ------
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, pin, pulse_output_n, timer_irq, err, lvl;
  logic [15:0] rnd = 16'hB6ED; // seed 46829
  int n_errors = 0, cmp_count = 0, irq_n = 0, tg_n = 0, i, per, ext;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} tevp_note_t;
  tevp_note_t notes[$]; // expected reads, oldest first
  tevp_timer dut_u (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .timer_input_pin(pin),
    .pulse_output_n, .timer_irq);
  tevp_pin_src src_u (.clk_sys, .pin);
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] seen, e);
    cmp_count++;
    if (seen !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    // look at ready mid-cycle, release only after the edge that takes it
    do begin
      @(negedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 9);
    if (pready !== 1'b1) begin
      n_errors++;
      complete_run();
    end
    err = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
    notes.push_back('{nm, e, m});
    apb(1'b0, a, 32'h0, 4'hF);
  endtask : rd
  // watcher: each read answer is judged against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk(notes[0].nm, prdata & notes[0].m, notes[0].e);
      void'(notes.pop_front());
    end
    if (timer_irq === 1'b1) irq_n++;
    if (!sys_rst && $changed(pulse_output_n)) tg_n++;
  end
  // ------
  // scenarios
  // ------
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk("out_rst", pulse_output_n, 1);
    rd("ctl_rst", TEVP_OFS_CTRL, 0, 32'hFFF);
    rd("sta_rst", TEVP_OFS_STATUS, 0, 32'h7FFFF);
    rd("hole", 8'h10, 0, 32'hFFFFFFFF);
    chk("slverr", err, 1);
    wr(TEVP_OFS_CTRL, 32'h018);
    apb(1'b1, TEVP_OFS_PERIOD, 32'h1234, 4'h1);
    repeat (8) @(posedge clk_sys);
    rd("per_lo", TEVP_OFS_PERIOD, 32'hFFFF, 32'hFFFF);
    $display("reset and staging done");
    rnd = lfsr(rnd);
    per = 3 + rnd[1:0];
    ext = rnd[3:2];
    wr(TEVP_OFS_PERIOD, 32'(per));
    wr(TEVP_OFS_CTRL, 32'h0DA);
    irq_n = 0;
    src_u.pulses(per + ext, 6, 6);
    repeat (10) @(posedge clk_sys);
    chk("ev_irq", irq_n, 1);
    rd("ev_cnt", TEVP_OFS_STATUS, 32'(ext), 32'hFFFF);
    rd("ev_cap", TEVP_OFS_DUTY, 32'(ext), 32'hFFFF);
    wr(TEVP_OFS_CTRL, 32'h018);
    wr(TEVP_OFS_PERIOD, 32'hFFFF);
    for (i = 0; i < 2; i++) begin
      wr(TEVP_OFS_CTRL, 32'h05C | 32'(i << 8));
      irq_n = 0;
      src_u.pulses(3, 8, 8);
      repeat (10) @(posedge clk_sys);
      chk("pw_irq", irq_n, i ? 3 : 5);
      rd("pw_rest", TEVP_OFS_STATUS, 32'(i), i ? 32'hFFFF : 32'h0);
      wr(TEVP_OFS_CTRL, 32'h018);
    end
    $display("event and width done");
    wr(TEVP_OFS_PERIOD, 32'h4);
    for (i = 0; i < 2; i++) begin
      wr(TEVP_OFS_CTRL, 32'h03B | 32'(i << 11));
      irq_n = 0;
      src_u.level(1'b1);
      repeat (60) @(posedge clk_sys);
      chk("win_irq", i ? irq_n == 0 : irq_n inside {[4:8]}, 1);
      src_u.level(1'b0);
      wr(TEVP_OFS_CTRL, 32'h018);
    end
    wr(TEVP_OFS_CTRL, 32'h01D);
    wr(TEVP_OFS_PERIOD, 32'h6);
    wr(TEVP_OFS_DUTY, 32'(1 + rnd[5:4]));
    wr(TEVP_OFS_CTRL, 32'h03D);
    irq_n = 0;
    tg_n = 0;
    repeat (100) @(posedge clk_sys);
    wr(TEVP_OFS_CTRL, 32'h01D);
    repeat (5) @(posedge clk_sys);
    lvl = pulse_output_n;
    chk("pg_tog", tg_n, irq_n);
    chk("pg_run", irq_n > 8, 1);
    repeat (40) @(posedge clk_sys);
    chk("pg_hold", pulse_output_n, lvl);
    wr(TEVP_OFS_CTRL, 32'h018);
    wr(TEVP_OFS_CTRL, 32'h41D);
    repeat (3) @(posedge clk_sys);
    chk("os_init", pulse_output_n, 0);
    irq_n = 0;
    wr(TEVP_OFS_CTRL, 32'h63D);
    repeat (60) @(posedge clk_sys);
    chk("os_irq", irq_n, 2);
    chk("os_out", pulse_output_n, 0);
    rd("os_ctl", TEVP_OFS_CTRL, 32'h61D, 32'hFFF);
    $display("window and pulse done");
    complete_run();
  end
endmodule : test_timer_event_window_pulse_gen
`default_nettype wire
